// ---- rtl/dmatm_top.v ----
// Purpose: Per-channel transfer mode control with shared address steps.
// Assumes: Sequencer inputs are on aclk; registers reached over AXI4-Lite.
// Notes:   Software writes win over a same-cycle hardware address update.
//
// Behaviour
// - Per-channel 16-bit transfer mode register.
// - Bit 15 enables automatic reinitialization.
// - Bit 14 enables the channel interrupt.
// - Circular mode: full, or half and full.
// - Multiframe: block end, or every frame.
// - Bits 11 and 5 ignore writes.
// - Bits 10-8 select source address update.
// - Bits 4-2 select destination address update.
// - No-modify mode keeps address constant.
// - Element step added after each element except the last of a multiframe block.
// - Frame step applied at frame end, except at a multiframe block end.
// - Either element step serves either direction.
// - Either frame step serves either direction.
// - Mode per channel, steps shared.
// - Double-word increments and decrements by two.
// - Element step signed, doubled in double-word.
// - Frame steps are signed 16-bit values.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`include "dmatm_consts.vh"

module dmatm_top (
  input  wire                 aclk,
  input  wire                 aresetn,
  input  wire [`DMATM_AW-1:0] s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  input  wire [`DMATM_DW-1:0] s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [`DMATM_AW-1:0] s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  output reg  [`DMATM_DW-1:0] s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  input  wire                 xfer_done,
  input  wire [`DMATM_CHW-1:0] xfer_chan,
  input  wire                 frame_last,
  input  wire                 block_last,
  input  wire                 half_full,
  input  wire                 buf_full,
  input  wire                 dbl_word,
  input  wire [`DMATM_CHW-1:0] sel_chan,
  output reg  [15:0]          cur_src_addr_q,
  output reg  [15:0]          cur_dst_addr_q,
  output reg  [1:0]           cur_src_space_q,
  output reg  [1:0]           cur_dst_space_q,
  output reg  [`DMATM_NCH-1:0] auto_reinit_q,
  output reg  [`DMATM_NCH-1:0] abu_mode_q,
  output reg  [`DMATM_NCH-1:0] chan_irq_q
);

  // Returns one for a channel number that exists.
  function chan_valid;
    input [`DMATM_CHW-1:0] ch;
    begin
      chan_valid = (ch < `DMATM_NCH_W);
    end
  endfunction

  // Returns one when a byte address hits a mapped register word.
  function addr_ok;
    input [`DMATM_AW-1:0] a;
    begin
      if (a[`DMATM_BYTE_HI:`DMATM_BYTE_LO] != 2'h0) begin
        addr_ok = 1'b0;
      end else if (a[`DMATM_GRP_HI:`DMATM_GRP_LO] == `DMATM_GRP_STEP) begin
        addr_ok = (a[`DMATM_IDX_HI:`DMATM_IDX_LO] < `DMATM_NSTEP);
      end else begin
        addr_ok = chan_valid(a[`DMATM_IDX_HI:`DMATM_IDX_LO]);
      end
    end
  endfunction

  // Merges the two low byte lanes of a write into a 16-bit register.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  reg [15:0] mode_q [0:`DMATM_NCH-1];
  reg [15:0] src_q  [0:`DMATM_NCH-1];
  reg [15:0] dst_q  [0:`DMATM_NCH-1];
  reg [15:0] elem_step_0_q;
  reg [15:0] elem_step_1_q;
  reg [15:0] frame_step_0_q;
  reg [15:0] frame_step_1_q;

  reg [`DMATM_AW-1:0] aw_addr_q;
  reg                 aw_held_q;
  reg [`DMATM_DW-1:0] w_data_q;
  reg [3:0]           w_strb_q;
  reg                 w_held_q;

  reg                 aw_held_d;
  reg                 w_held_d;
  reg                 bvalid_d;
  reg                 rvalid_d;
  reg [`DMATM_DW-1:0] rdata_d;
  reg [1:0]           rresp_d;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire wr_ok    = addr_ok(aw_addr_q);
  wire [1:0] wr_grp = aw_addr_q[`DMATM_GRP_HI:`DMATM_GRP_LO];
  wire [2:0] wr_idx = aw_addr_q[`DMATM_IDX_HI:`DMATM_IDX_LO];
  // Group and word index of the read address on offer.
  wire [1:0] rd_grp = s_axi_araddr[`DMATM_GRP_HI:`DMATM_GRP_LO];
  wire [2:0] rd_idx = s_axi_araddr[`DMATM_IDX_HI:`DMATM_IDX_LO];

  // Next state of the write and read channel handshakes.
  always @* begin
    aw_held_d = (aw_held_q | aw_take) & ~do_write;
    w_held_d  = (w_held_q | w_take) & ~do_write;
    bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
    rvalid_d  = ar_take | (s_axi_rvalid & ~s_axi_rready);
  end

  // Read data for the address being accepted; reserved bits read zero.
  always @* begin
    rdata_d = {`DMATM_DW{1'b0}};
    rresp_d = `DMATM_RESP_OKAY;
    if (!addr_ok(s_axi_araddr)) begin
      rresp_d = `DMATM_RESP_SLV;
    end else begin
      case (rd_grp)
        `DMATM_GRP_MODE: rdata_d[15:0] = mode_q[rd_idx];
        `DMATM_GRP_SRC:  rdata_d[15:0] = src_q[rd_idx];
        `DMATM_GRP_DST:  rdata_d[15:0] = dst_q[rd_idx];
        default: begin
          case (rd_idx)
            `DMATM_OFF_E0: rdata_d[15:0] = elem_step_0_q;
            `DMATM_OFF_E1: rdata_d[15:0] = elem_step_1_q;
            `DMATM_OFF_F0: rdata_d[15:0] = frame_step_0_q;
            default:       rdata_d[15:0] = frame_step_1_q;
          endcase
        end
      endcase
    end
  end

  // Bus handshake registers; each ready drops while its item is held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= {`DMATM_AW{1'b0}};
      w_data_q      <= {`DMATM_DW{1'b0}};
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DMATM_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= {`DMATM_DW{1'b0}};
      s_axi_rresp   <= `DMATM_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      s_axi_awready <= ~aw_held_d & ~bvalid_d;
      s_axi_wready  <= ~w_held_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      if (do_write) begin
        s_axi_bresp <= wr_ok ? `DMATM_RESP_OKAY : `DMATM_RESP_SLV;
      end
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rresp_d;
      end
    end
  end

  // Mode of the channel whose element has just moved.
  wire        chan_ok  = chan_valid(xfer_chan);
  wire [15:0] cur_mode = chan_ok ? mode_q[xfer_chan] : `DMATM_RST16;
  wire [15:0] src_next;
  wire [15:0] dst_next;

  dmatm_addr_step u_src_step (
    .addr         (chan_ok ? src_q[xfer_chan] : `DMATM_RST16),
    .mode         (cur_mode[`DMATM_SUPD_HI:`DMATM_SUPD_LO]),
    .elem_step_0  (elem_step_0_q),
    .elem_step_1  (elem_step_1_q),
    .frame_step_0 (frame_step_0_q),
    .frame_step_1 (frame_step_1_q),
    .frame_end    (frame_last),
    .dbl_word     (dbl_word),
    .next_addr    (src_next)
  );

  dmatm_addr_step u_dst_step (
    .addr         (chan_ok ? dst_q[xfer_chan] : `DMATM_RST16),
    .mode         (cur_mode[`DMATM_DUPD_HI:`DMATM_DUPD_LO]),
    .elem_step_0  (elem_step_0_q),
    .elem_step_1  (elem_step_1_q),
    .frame_step_0 (frame_step_0_q),
    .frame_step_1 (frame_step_1_q),
    .frame_end    (frame_last),
    .dbl_word     (dbl_word),
    .next_addr    (dst_next)
  );

  wire hold_addr = block_last & ~cur_mode[`DMATM_B_COUNTER_MODE_SELECT];
  wire hw_upd    = xfer_done & chan_ok & ~hold_addr;

  integer i;

  // Register file: hardware address updates first, software writes last.
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `DMATM_NCH; i = i + 1) begin
        mode_q[i] <= `DMATM_RST16;
        src_q[i]  <= `DMATM_RST16;
        dst_q[i]  <= `DMATM_RST16;
      end
      elem_step_0_q  <= `DMATM_RST16;
      elem_step_1_q  <= `DMATM_RST16;
      frame_step_0_q <= `DMATM_RST16;
      frame_step_1_q <= `DMATM_RST16;
    end else begin
      if (hw_upd) begin
        src_q[xfer_chan] <= src_next;
        dst_q[xfer_chan] <= dst_next;
      end
      if (do_write && wr_ok) begin
        case (wr_grp)
          `DMATM_GRP_MODE: mode_q[wr_idx] <=
            merge16(mode_q[wr_idx], w_data_q, w_strb_q) & `DMATM_MODE_WMASK;
          `DMATM_GRP_SRC:  src_q[wr_idx] <= merge16(src_q[wr_idx], w_data_q, w_strb_q);
          `DMATM_GRP_DST:  dst_q[wr_idx] <= merge16(dst_q[wr_idx], w_data_q, w_strb_q);
          default: begin
            case (wr_idx)
              `DMATM_OFF_E0: elem_step_0_q  <= merge16(elem_step_0_q, w_data_q, w_strb_q);
              `DMATM_OFF_E1: elem_step_1_q  <= merge16(elem_step_1_q, w_data_q, w_strb_q);
              `DMATM_OFF_F0: frame_step_0_q <= merge16(frame_step_0_q, w_data_q, w_strb_q);
              default:       frame_step_1_q <= merge16(frame_step_1_q, w_data_q, w_strb_q);
            endcase
          end
        endcase
      end
    end
  end

  // Interrupt condition of the moving channel from its timing and counter mode.
  reg irq_hit;
  always @* begin
    irq_hit = 1'b0;
    if (cur_mode[`DMATM_B_COUNTER_MODE_SELECT]) begin
      irq_hit = buf_full | (cur_mode[`DMATM_B_IRQ_TIMING_SELECT] & half_full);
    end else begin
      irq_hit = block_last | (cur_mode[`DMATM_B_IRQ_TIMING_SELECT] & frame_last);
    end
  end

  // Per-channel interrupt pulses, one cycle wide.
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_irq_q <= {`DMATM_NCH{1'b0}};
    end else begin
      chan_irq_q <= {`DMATM_NCH{1'b0}};
      if (xfer_done && chan_ok && cur_mode[`DMATM_B_IRQM] && irq_hit) begin
        chan_irq_q[xfer_chan] <= 1'b1;
      end
    end
  end

  // Mode bits that the sequencer needs for every channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      auto_reinit_q <= {`DMATM_NCH{1'b0}};
      abu_mode_q    <= {`DMATM_NCH{1'b0}};
    end else begin
      for (i = 0; i < `DMATM_NCH; i = i + 1) begin
        auto_reinit_q[i] <= mode_q[i][`DMATM_B_AUTO];
        abu_mode_q[i]    <= mode_q[i][`DMATM_B_COUNTER_MODE_SELECT];
      end
    end
  end

  // Addresses and spaces of the channel the sequencer is about to serve.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cur_src_addr_q  <= `DMATM_RST16;
      cur_dst_addr_q  <= `DMATM_RST16;
      cur_src_space_q <= `DMATM_SPC_PROG;
      cur_dst_space_q <= `DMATM_SPC_PROG;
    end else if (chan_valid(sel_chan)) begin
      cur_src_addr_q  <= src_q[sel_chan];
      cur_dst_addr_q  <= dst_q[sel_chan];
      cur_src_space_q <= mode_q[sel_chan][`DMATM_SSPC_HI:`DMATM_SSPC_LO];
      cur_dst_space_q <= mode_q[sel_chan][`DMATM_DSPC_HI:`DMATM_DSPC_LO];
    end else begin
      cur_src_addr_q  <= `DMATM_RST16;
      cur_dst_addr_q  <= `DMATM_RST16;
      cur_src_space_q <= `DMATM_SPC_PROG;
      cur_dst_space_q <= `DMATM_SPC_PROG;
    end
  end

endmodule // dmatm_top

// ---- rtl/dmatm_consts.vh ----
// Purpose: Shared constants of the channel transfer mode block.
// Assumes: Included by bare name from every design file of the block.
// Notes:   Definitions only; no logic lives here.
`ifndef DMATM_CONSTS_VH
`define DMATM_CONSTS_VH

// Channel count and register bus geometry.
`define DMATM_NCH        6
`define DMATM_CHW        3
`define DMATM_NCH_W      3'h6
`define DMATM_AW         7
`define DMATM_DW         32
`define DMATM_RW         16

// Register address fields: group codes of per-channel words and word indices of the shared steps.
`define DMATM_GRP_MODE   2'h0
`define DMATM_GRP_SRC    2'h1
`define DMATM_GRP_DST    2'h2
`define DMATM_GRP_STEP   2'h3
`define DMATM_OFF_E0     3'h0
`define DMATM_OFF_E1     3'h1
`define DMATM_OFF_F0     3'h2
`define DMATM_OFF_F1     3'h3
`define DMATM_NSTEP      3'h4

// Byte address fields: misalignment bits, register group and word index.
`define DMATM_BYTE_HI    1
`define DMATM_BYTE_LO    0
`define DMATM_GRP_HI     6
`define DMATM_GRP_LO     5
`define DMATM_IDX_HI     4
`define DMATM_IDX_LO     2

// Field positions of channel_transfer_mode.
`define DMATM_B_AUTO     15
`define DMATM_B_IRQM     14
`define DMATM_B_IRQ_TIMING_SELECT     13
`define DMATM_B_COUNTER_MODE_SELECT    12
`define DMATM_SUPD_HI    10
`define DMATM_SUPD_LO    8
`define DMATM_SSPC_HI    7
`define DMATM_SSPC_LO    6
`define DMATM_DUPD_HI    4
`define DMATM_DUPD_LO    2
`define DMATM_DSPC_HI    1
`define DMATM_DSPC_LO    0

// Writable bits of channel_transfer_mode; bits 11 and 5 stay zero.
`define DMATM_MODE_WMASK 16'hf7df
`define DMATM_RST16      16'h0000

// Address update codes.
`define DMATM_UPD_KEEP   3'h0
`define DMATM_UPD_INC    3'h1
`define DMATM_UPD_DEC    3'h2
`define DMATM_UPD_E0     3'h3
`define DMATM_UPD_E1     3'h4
`define DMATM_UPD_EF0    3'h5
`define DMATM_UPD_EF1    3'h6
`define DMATM_UPD_RSVD   3'h7

// Address space codes.
`define DMATM_SPC_PROG   2'h0
`define DMATM_SPC_DATA   2'h1
`define DMATM_SPC_IO     2'h2

// Bus responses.
`define DMATM_RESP_OKAY  2'h0
`define DMATM_RESP_SLV   2'h2

`endif

// ---- rtl/dmatm_addr_step.v ----
// Purpose: Next-address calculation for one direction of a transfer.
// Assumes: Pure combinational; caller registers the result.
// Notes:   Addresses and steps are 16 bits and wrap modulo 2^16.
`include "dmatm_consts.vh"

module dmatm_addr_step (
  input  wire [15:0] addr,
  input  wire [2:0]  mode,
  input  wire [15:0] elem_step_0,
  input  wire [15:0] elem_step_1,
  input  wire [15:0] frame_step_0,
  input  wire [15:0] frame_step_1,
  input  wire        frame_end,
  input  wire        dbl_word,
  output reg  [15:0] next_addr
);

  reg [15:0] step;

  // Select the step for this transfer; element steps double for double-word elements, frame steps do not.
  always @* begin
    step = `DMATM_RST16;
    case (mode)
      `DMATM_UPD_KEEP: step = `DMATM_RST16;
      `DMATM_UPD_INC:  step = dbl_word ? 16'h0002 : 16'h0001;
      `DMATM_UPD_DEC:  step = dbl_word ? 16'hfffe : 16'hffff;
      `DMATM_UPD_E0:   step = dbl_word ? {elem_step_0[14:0], 1'b0} : elem_step_0;
      `DMATM_UPD_E1:   step = dbl_word ? {elem_step_1[14:0], 1'b0} : elem_step_1;
      `DMATM_UPD_EF0:  step = frame_end ? frame_step_0 :
                              (dbl_word ? {elem_step_0[14:0], 1'b0} : elem_step_0);
      `DMATM_UPD_EF1:  step = frame_end ? frame_step_1 :
                              (dbl_word ? {elem_step_1[14:0], 1'b0} : elem_step_1);
      // Reserved code holds the address as a safe choice.
      default:         step = `DMATM_RST16;
    endcase
    next_addr = addr + step;
  end

endmodule // dmatm_addr_step

// ---- rtl/placeholder_none.v ----
// Purpose: Intentionally empty unit kept out of the build.
// Assumes: Nothing.
// Notes:   Holds no module.

// ---- verification/dmatm_top_sva.sv ----
// Purpose: Port-level checks of the transfer mode block.
// Assumes: One aclk domain with a synchronous active-low reset.
// Notes:   Bound to every dmatm_top instance.
`include "dmatm_consts.vh"
module dmatm_chk (
  input logic                  aclk,
  input logic                  aresetn,
  input logic                  s_axi_awvalid,
  input logic                  s_axi_awready,
  input logic                  s_axi_wvalid,
  input logic                  s_axi_wready,
  input logic                  s_axi_bvalid,
  input logic [`DMATM_AW-1:0]  s_axi_araddr,
  input logic                  s_axi_arvalid,
  input logic                  s_axi_arready,
  input logic [`DMATM_DW-1:0]  s_axi_rdata,
  input logic                  s_axi_rvalid,
  input logic                  xfer_done,
  input logic [`DMATM_CHW-1:0] xfer_chan,
  input logic [`DMATM_CHW-1:0] sel_chan,
  input logic [1:0]            cur_src_space_q,
  input logic [1:0]            cur_dst_space_q,
  input logic [`DMATM_NCH-1:0] chan_irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshakes that start a write, a read and a mode read.
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence mode_rd;
    rd_take ##0 (s_axi_araddr < 7'h18);
  endsequence
  wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  wr_busy_a: assert property (wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while busy");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data missing");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  rsvd_read_a: assert property (mode_rd |=> !s_axi_rdata[11] && !s_axi_rdata[5])
    else $error("reserved mode bit reads one");
  irq_cause_a: assert property (|chan_irq_q |-> $past(xfer_done) &&
    chan_irq_q == (6'h01 << $past(xfer_chan))) else $error("interrupt without transfer");
  ghost_chan_a: assert property (xfer_done && xfer_chan > 3'h5 |=> chan_irq_q == 6'h00)
    else $error("interrupt for absent channel");
  space_off_a: assert property ((sel_chan > 3'h5) [*2] |->
    cur_src_space_q == 2'h0 && cur_dst_space_q == 2'h0) else $error("space of absent channel");
endmodule // dmatm_chk

bind dmatm_top dmatm_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .xfer_done, .xfer_chan, .sel_chan,
  .cur_src_space_q, .cur_dst_space_q, .chan_irq_q);

// ---- verification/dmatm_seq_model.sv ----
// Purpose: Channel sequencer stand-in that issues single element transfers.
// Assumes: Driven from the bench on the rising edge of aclk.
// Notes:   Channel and qualifiers toggle between transfers.
module dmatm_seq_model (
  input  logic       aclk,
  input  logic       go,
  input  logic [2:0] chan,
  input  logic [4:0] flags,
  output logic       xfer_done,
  output logic [2:0] xfer_chan,
  output logic [4:0] qual
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outputs start quiet at time zero.
  initial begin
    xfer_done = 1'b0;
    {xfer_chan, qual} = 8'h00;
  end
  always @(posedge aclk) begin
    xfer_done <= go;
    if (go)
      {xfer_chan, qual} <= {chan, flags};
    else
      {xfer_chan, qual} <= ~{xfer_chan, qual};
  end
endmodule // dmatm_seq_model

// ---- verification/dmatm_top_tb_top.sv ----
// Purpose: Self-checking bench of the transfer mode block.
// Assumes: 20 MHz aclk; registers reached by an AXI4-Lite master task.
// Notes:   A monitor checks reads and write responses from queues.
`include "dmatm_consts.vh"
module dmatm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [6:0]  s_axi_awaddr = 7'h00;
  logic [6:0]  s_axi_araddr = 7'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        go = 1'b0;
  logic [2:0]  chan = 3'h0;
  logic [2:0]  sel_chan = 3'h0;
  logic [4:0]  flags = 5'h00;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, cur_src_space_q, cur_dst_space_q;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] cur_src_addr_q, cur_dst_addr_q;
  wire  [5:0]  auto_reinit_q, abu_mode_q, chan_irq_q;
  wire         xfer_done, frame_last, block_last, half_full, buf_full, dbl_word;
  wire  [2:0]  xfer_chan;
  logic [33:0] rq[$];
  logic [1:0]  wq[$];
  logic [15:0] st[4];
  logic [15:0] md[6];
  logic [15:0] a0, a1, e0, e1;
  logic [2:0]  k, dk;
  logic [1:0]  sp;
  logic [3:0]  mm;
  logic [4:0]  fv;
  logic        fl, db;
  integer      errors = 0, cmp_count = 0, seed = 71, i, c;

  // Free-running 50 ns clock.
  always #25 aclk = ~aclk;

  dmatm_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .xfer_done, .xfer_chan, .frame_last, .block_last, .half_full, .buf_full,
    .dbl_word, .sel_chan, .cur_src_addr_q, .cur_dst_addr_q, .cur_src_space_q,
    .cur_dst_space_q, .auto_reinit_q, .abu_mode_q, .chan_irq_q);
  dmatm_seq_model u_seq (.aclk, .go, .chan, .flags, .xfer_done, .xfer_chan,
    .qual({frame_last, block_last, half_full, buf_full, dbl_word}));

  // Compares one result and counts it.
  task chk(input string n, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // One write; address and data are released as each is taken.
  task axw(input logic [6:0] a, input logic [31:0] d, input logic [1:0] e);
    wq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  // One read; the expected response and data go to the queue.
  task axr(input logic [6:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // One element through the sequencer model, then the interrupt outputs.
  task xfer(input logic [2:0] ch, input logic [4:0] f, input logic [5:0] ei);
    @(posedge aclk);
    go <= 1'b1;
    chan <= ch;
    flags <= f;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    #1 chk("chan_irq_q", ei, chan_irq_q);
  endtask

  // Expected address after one element for update code u.
  function automatic logic [15:0] nxt(logic [15:0] a, logic [2:0] u, logic f, logic d);
    case (u)
      3'h1: nxt = a + (16'h0001 << d);
      3'h2: nxt = a - (16'h0001 << d);
      3'h3, 3'h4: nxt = a + (st[u - 3'h3] << d);
      3'h5, 3'h6: nxt = f ? a + st[u - 3'h3] : a + (st[u - 3'h5] << d);
      default: nxt = a;
    endcase
  endfunction

  // Results are taken off the queues as the handshakes complete.
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk("s_axi_bresp", wq.pop_front(), s_axi_bresp);
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk("s_axi_rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    #500000;
    errors++;
    $display("watchdog expired");
    test_done;
  end

  // Main sequence of tests.
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 32; i++)
      axr({i[4:0], 2'b00}, (i < 24 ? i % 8 < 6 : i < 28) ? 34'h0 : {2'h2, 32'h0});
    $display("test reset_map done");
    for (i = 0; i < 6; i++) begin
      md[i] = 16'($random(seed)) & 16'hfb6d;
      axw({i[4:0], 2'b00}, {16'h0, md[i]}, 2'h0);
    end
    for (i = 0; i < 6; i++) begin
      axr({i[4:0], 2'b00}, {18'h0, md[i] & 16'hf7df});
      chk("auto_reinit_q", md[i][15], auto_reinit_q[i]);
      chk("abu_mode_q", md[i][12], abu_mode_q[i]);
    end
    axw(7'h7c, $random(seed), 2'h2);
    axw(7'h01, 32'h0000ffff, 2'h2);
    axr(7'h00, {18'h0, md[0] & 16'hf7df});
    s_axi_wstrb <= 4'h2;
    axw(7'h00, 32'h0000ffff, 2'h0);
    s_axi_wstrb <= 4'hf;
    axr(7'h00, {18'h0, 8'hf7, md[0][7:0] & 8'hdf});
    $display("test mode_regs done");
    for (i = 0; i < 4; i++) begin
      st[i] = 16'($random(seed));
      axw(7'h60 + {i[4:0], 2'b00}, {16'h0, st[i]}, 2'h0);
    end
    for (c = 0; c < 7; c++) begin
      i = c % 6;
      k = c[2:0];
      dk = 3'h6 - k;
      sp = (k == 3'h3) ? 2'h0 : k[1:0];
      a0 = 16'($random(seed));
      a1 = 16'($random(seed));
      {fl, db} = 2'($random(seed));
      e0 = (c[1] && !c[0]) ? a0 : nxt(a0, k, fl, db);
      e1 = (c[1] && !c[0]) ? a1 : nxt(a1, dk, fl, db);
      axw({i[4:0], 2'b00}, {16'h0, 3'h0, c[0], 1'b0, k, sp, 1'b0, dk, sp}, 2'h0);
      axw({2'b01, i[2:0], 2'b00}, {16'h0, a0}, 2'h0);
      axw({2'b10, i[2:0], 2'b00}, {16'h0, a1}, 2'h0);
      sel_chan <= i[2:0];
      xfer(i[2:0], {fl, c[1], 2'h0, db}, 6'h00);
      axr({2'b01, i[2:0], 2'b00}, {18'h0, e0});
      axr({2'b10, i[2:0], 2'b00}, {18'h0, e1});
      chk("cur_src_addr_q", e0, cur_src_addr_q);
      chk("cur_dst_addr_q", e1, cur_dst_addr_q);
      chk("cur_src_space_q", sp, cur_src_space_q);
      chk("cur_dst_space_q", sp, cur_dst_space_q);
    end
    $display("test addr_update done");
    for (c = 0; c < 32; c++) begin
      mm = c[3:0];
      fv = 5'($random(seed)) & 5'h1e;
      axw(7'h08, {16'h0, mm, 12'h000}, 2'h0);
      xfer(3'h2, fv, {3'h0, mm[2] && (mm[0] ? fv[1] || mm[1] && fv[2] :
        fv[3] || mm[1] && fv[4]), 2'h0});
    end
    xfer(3'h7, 5'h1e, 6'h00);
    sel_chan <= 3'h7;
    repeat (3) @(posedge aclk);
    chk("cur_src_space_q", 2'h0, cur_src_space_q);
    $display("test irq_timing done");
    repeat (4) @(posedge aclk);
    test_done;
  end
endmodule // dmatm_top_tb_top
